// ### rtl/twb_pkg.sv
// Shared constants and types of the two-wire bus clock and address block
package twb_pkg;
  localparam logic [31:0] ADDR_CLK_SEL = 32'hFFFFF344;
  localparam logic [31:0] ADDR_OWN = 32'hFFFFF346;
  localparam logic [31:0] ADDR_SHIFT = 32'hFFFFF348;
  localparam logic [31:0] ADDR_EXP = 32'hFFFFF34A;
  localparam int CS_SDA_LVL = 4;
  localparam int CS_SCL_LVL = 5;
  localparam int CS_FILT = 2;
  localparam int CS_SPEED = 3;
  localparam int EXP_CLX = 0;
  localparam logic [3:0] RST_CLK_SEL = 4'h0;
  localparam logic [7:0] RST_OWN = 8'h00;
  localparam logic RST_CLX = 1'b0;
  localparam logic [7:0] RST_SHIFT = 8'hFF;
  // Divisors of one transfer clock period
  localparam logic [7:0] DIV_STD_A = 8'h2C;
  localparam logic [7:0] DIV_STD_B = 8'h56;
  localparam logic [7:0] DIV_STD_C = 8'hAC;
  localparam logic [7:0] DIV_STD_TMR = 8'h42;
  localparam logic [7:0] DIV_HS_A = 8'h18;
  localparam logic [7:0] DIV_HS_C = 8'h30;
  localparam logic [7:0] DIV_HS_TMR = 8'h12;
  localparam logic [7:0] DIV_HS_X = 8'h0C;
  localparam logic [3:0] SEL_STD_A = 4'h0;
  localparam logic [3:0] SEL_STD_B = 4'h1;
  localparam logic [3:0] SEL_STD_C = 4'h2;
  localparam logic [3:0] SEL_STD_TMR = 4'h3;
  localparam logic [3:0] SEL_HS_A = 4'h4;
  localparam logic [3:0] SEL_HS_C = 4'h6;
  localparam logic [3:0] SEL_HS_TMR = 4'h7;
  localparam logic [3:0] SEL_HS_X = 4'hC;
  localparam logic [1:0] DIV_CODE_TMR = 2'h3;
  localparam logic [3:0] BIT_IDLE = 4'h0;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam int FILT_LEN_DEF = 2;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int DATA_W = 8;
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_LOW, M_HIGH, M_WAIT,
    M_RS_LOW, M_RS_HIGH, M_STOP_LOW, M_STOP_HIGH
  } twb_mstate_t;
endpackage

// ### rtl/twb_stream_if.sv
// Valid/ready byte stream between the core and its receive FIFO
`timescale 1ns/1ps
`default_nettype none
interface twb_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/twb_line_sync.sv
// Three-stage pin synchroniser with optional stability filter
`timescale 1ns/1ps
`default_nettype none
module twb_line_sync #(
  parameter int FILT_LEN = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic line_in,
  input wire logic filt_on,
  output logic level
);
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [7:0] cnt_q, cnt_d;

  always_comb begin
    lvl_d = lvl_q;
    cnt_d = 8'h00;
    if (s2_q == s3_q && s3_q != lvl_q) begin
      if (!filt_on || cnt_q == 8'(FILT_LEN - 1)) begin
        lvl_d = s3_q;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
      cnt_q <= 8'h00;
    end else begin
      s1_q <= line_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  assign level = lvl_q;
endmodule
`default_nettype wire

// ### rtl/twb_fifo.sv
// Receive byte FIFO, width and depth set by parameters
`timescale 1ns/1ps
`default_nettype none
module twb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  twb_stream_if.snk push,
  twb_stream_if.src pop
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic full, empty, do_push, do_pop;

  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign push.ready = !full;
  assign pop.valid = !empty;
  assign pop.data = mem[rd_q[AW-1:0]];
  assign do_push = push.valid && !full;
  assign do_pop = pop.ready && !empty;

  always_comb begin
    wr_d = do_push ? wr_q + (AW+1)'(1) : wr_q;
    rd_d = do_pop ? rd_q + (AW+1)'(1) : rd_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_q[AW-1:0]] <= push.data;
    end
  end
endmodule
`default_nettype wire

// ### rtl/twb_core.sv
// Two-wire bus clock generation, line monitor, shifting and address match
// How it works
// - Clock select bit 5 shows sampled clock line while enabled, else zero.
// - Clock select bit 4 shows sampled data line while enabled, else zero.
// - Speed bit picks standard mode at 0, high-speed mode at 1.
// - Input filter acts only when enabled and high-speed mode selected.
// - Filter setting never changes the generated clock rate.
// - Standard mode divides main clock by 44, 86, 172 or timer by 66.
// - High-speed divides by 24, 48, timer by 18, or 12 when extended.
// - Timer pulse is taken internally without any pin setup.
// - Both lines only pulled low, never driven high.
// - Only the master makes start, address and stop and toggles the clock; a selected slave only holds it low to wait.
// - Receiver of a byte normally drives the acknowledge bit.
// - A low held clock stretches the cycle; master waits for release.
// - Data falling while clock high is a start, detected here.
// - Start trigger emits a start from idle only after a stop was seen.
// - Detected start sets the start seen flag.
// - First seven bits after start are the address.
// - Matching address selects the slave until next start or stop.
// - Address and direction go out from the shift register top bits.
// - Eighth address bit: zero master writes, one master reads.
// - Data rising while clock high is a stop, detected here.
// - Stop sets stop flag; cleared by disable, reset, next address clock.
// - Receiver pulls data low during the ninth clock.
`timescale 1ns/1ps
`default_nettype none
module twb_core
  import twb_pkg::*;
#(
  parameter int FILT_LEN = FILT_LEN_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic unit_enable,
  input wire logic start_trigger,
  input wire logic stop_trigger,
  input wire logic timer_two_out,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic start_seen_flag,
  output logic stop_seen_flag,
  output logic ack_seen_flag,
  output logic slave_selected,
  output logic master_busy,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data
);
  logic scl_lvl, sda_lvl, filt_on;
  logic scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  // Register file state
  logic [3:0] cs_q, cs_d;
  logic clx_q, clx_d;
  logic [7:0] own_q, own_d;
  logic [7:0] rdata_q, rdata_d;
  logic wr_cs, wr_own, wr_sh, wr_exp;
  logic [7:0] cs_view;

  // Byte engine state
  logic [7:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic in_addr_q, in_addr_d;
  logic tx_q, tx_d;
  logic sel_q, sel_d;
  logic ack_drv_q, ack_drv_d;
  logic std_q, std_d;
  logic spd_q, spd_d;
  logic ackd_q, ackd_d;
  logic pend_q, pend_d;
  logic wait_q, wait_d;
  logic obit_q, obit_d;
  logic push_rdy;

  // Master clock generator state
  twb_mstate_t mst_q, mst_d;
  logic mbusy_q, mbusy_d;
  logic [7:0] cnt_q, cnt_d;
  logic tm2_prev_q;
  logic [7:0] div, half_m1;
  logic use_tmr, tick, half_done, start_go;
  logic m_scl_low, m_sda_low, eng_drv_ok, eng_sda_low;

  twb_stream_if #(.W(DATA_W)) push_if ();
  twb_stream_if #(.W(DATA_W)) pop_if ();

  assign filt_on = cs_q[CS_FILT] && cs_q[CS_SPEED];

  twb_line_sync #(.FILT_LEN(FILT_LEN)) u_scl_sync (
    .core_clk(core_clk),
    .rst(rst),
    .line_in(scl_i),
    .filt_on(filt_on),
    .level(scl_lvl)
  );

  twb_line_sync #(.FILT_LEN(FILT_LEN)) u_sda_sync (
    .core_clk(core_clk),
    .rst(rst),
    .line_in(sda_i),
    .filt_on(filt_on),
    .level(sda_lvl)
  );

  twb_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  assign push_if.valid = pend_q;
  assign push_if.data = sh_q;
  assign push_rdy = push_if.ready;
  assign rx_valid = pop_if.valid;
  assign rx_data = pop_if.data;
  assign pop_if.ready = rx_ready;

  assign scl_rise = scl_lvl && !scl_prev_q;
  assign scl_fall = !scl_lvl && scl_prev_q;
  assign start_det = scl_lvl && scl_prev_q && sda_prev_q && !sda_lvl;
  assign stop_det = scl_lvl && scl_prev_q && !sda_prev_q && sda_lvl;

  // ---------------- Registers ----------------
  assign wr_cs = reg_wr && reg_addr == ADDR_CLK_SEL;
  assign wr_own = reg_wr && reg_addr == ADDR_OWN;
  assign wr_sh = reg_wr && reg_addr == ADDR_SHIFT;
  assign wr_exp = reg_wr && reg_addr == ADDR_EXP;

  always_comb begin
    cs_view = {2'b00, unit_enable && scl_lvl, unit_enable && sda_lvl, cs_q};
    cs_d = wr_cs ? reg_wdata[3:0] : cs_q;
    clx_d = wr_exp ? reg_wdata[EXP_CLX] : clx_q;
    own_d = wr_own ? reg_wdata : own_q;
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CLK_SEL: rdata_d = cs_view;
        ADDR_OWN: rdata_d = own_q;
        ADDR_SHIFT: rdata_d = sh_q;
        ADDR_EXP: rdata_d = {7'h00, clx_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_q <= RST_CLK_SEL;
      clx_q <= RST_CLX;
      own_q <= RST_OWN;
      rdata_q <= 8'h00;
    end else begin
      cs_q <= cs_d;
      clx_q <= clx_d;
      own_q <= own_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------- Clock divider ----------------
  // Prohibited codes fall back to the slowest rate rather than an untested one
  always_comb begin
    case ({clx_q, cs_q[CS_SPEED], cs_q[1:0]})
      SEL_STD_A: div = DIV_STD_A;
      SEL_STD_B: div = DIV_STD_B;
      SEL_STD_C: div = DIV_STD_C;
      SEL_STD_TMR: div = DIV_STD_TMR;
      SEL_HS_A: div = DIV_HS_A;
      SEL_HS_C: div = DIV_HS_C;
      SEL_HS_TMR: div = DIV_HS_TMR;
      SEL_HS_X: div = DIV_HS_X;
      default: div = DIV_STD_C;
    endcase
  end

  // Divider ignores the filter bit, so the rate holds either way
  assign half_m1 = {1'b0, div[7:1]} - 8'h01;
  assign use_tmr = !clx_q && cs_q[1:0] == DIV_CODE_TMR;
  assign tick = use_tmr ? (timer_two_out && !tm2_prev_q) : 1'b1;
  assign half_done = tick && cnt_q == half_m1;
  assign start_go = start_trigger && spd_q && unit_enable;

  // ---------------- Master sequencer ----------------
  always_comb begin
    mst_d = mst_q;
    mbusy_d = mbusy_q;
    cnt_d = tick ? cnt_q + 8'h01 : cnt_q;
    case (mst_q)
      M_IDLE: begin
        cnt_d = 8'h00;
        if (start_go) begin
          mst_d = M_START;
          mbusy_d = 1'b1;
        end
      end
      M_START: if (half_done) mst_d = M_LOW;
      M_LOW: if (half_done) mst_d = M_HIGH;
      M_HIGH: begin
        // Hold the count while the clock line still reads low, so a held clock stretches the phase
        if (half_done && !scl_lvl) begin
          cnt_d = cnt_q;
        end else if (half_done) begin
          mst_d = (bit_q == BIT_ACK) ? M_WAIT : M_LOW;
        end
      end
      M_WAIT: begin
        cnt_d = 8'h00;
        if (stop_trigger) begin
          mst_d = M_STOP_LOW;
        end else if (start_trigger) begin
          mst_d = M_RS_LOW;
        end else if (wr_sh) begin
          mst_d = M_LOW;
        end
      end
      M_RS_LOW: if (half_done) mst_d = M_RS_HIGH;
      M_RS_HIGH: begin
        if (!scl_lvl) begin
          cnt_d = 8'h00;
        end else if (half_done) begin
          mst_d = M_START;
        end
      end
      M_STOP_LOW: if (half_done) mst_d = M_STOP_HIGH;
      M_STOP_HIGH: begin
        if (!scl_lvl) begin
          cnt_d = 8'h00;
        end else if (half_done) begin
          mst_d = M_IDLE;
          mbusy_d = 1'b0;
        end
      end
      default: mst_d = M_IDLE;
    endcase
    if (mst_d != mst_q) begin
      cnt_d = 8'h00;
    end
    if (!unit_enable) begin
      mst_d = M_IDLE;
      mbusy_d = 1'b0;
      cnt_d = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mst_q <= M_IDLE;
      mbusy_q <= 1'b0;
      cnt_q <= 8'h00;
      tm2_prev_q <= 1'b0;
    end else begin
      mst_q <= mst_d;
      mbusy_q <= mbusy_d;
      cnt_q <= cnt_d;
      tm2_prev_q <= timer_two_out;
    end
  end

  // Master holds the clock low in low phases and keeps data low around edges
  assign m_scl_low = mst_q inside {M_LOW, M_WAIT, M_RS_LOW, M_STOP_LOW};
  assign m_sda_low = mst_q inside {M_START, M_STOP_LOW, M_STOP_HIGH};
  assign eng_drv_ok = !(mst_q inside {M_RS_LOW, M_RS_HIGH, M_STOP_LOW, M_STOP_HIGH});

  // ---------------- Byte engine ----------------
  always_comb begin
    sh_d = wr_sh ? reg_wdata : sh_q;
    bit_d = bit_q;
    in_addr_d = in_addr_q;
    tx_d = tx_q;
    sel_d = sel_q;
    ack_drv_d = ack_drv_q;
    std_d = std_q;
    spd_d = spd_q;
    ackd_d = ackd_q;
    pend_d = pend_q && !push_rdy;
    wait_d = wait_q && !wr_sh;
    // Next data bit is taken up only while the clock line reads low
    obit_d = scl_lvl ? obit_q : sh_q[7];
    if (!unit_enable) begin
      bit_d = BIT_IDLE;
      in_addr_d = 1'b0;
      tx_d = 1'b0;
      sel_d = 1'b0;
      ack_drv_d = 1'b0;
      std_d = 1'b0;
      spd_d = 1'b0;
      ackd_d = 1'b0;
      pend_d = 1'b0;
      wait_d = 1'b0;
    end else if (start_det) begin
      std_d = 1'b1;
      in_addr_d = 1'b1;
      bit_d = BIT_IDLE;
      sel_d = 1'b0;
      ack_drv_d = 1'b0;
      tx_d = mbusy_q;
      wait_d = 1'b0;
    end else if (stop_det) begin
      spd_d = 1'b1;
      std_d = 1'b0;
      sel_d = 1'b0;
      bit_d = BIT_IDLE;
      in_addr_d = 1'b0;
      ack_drv_d = 1'b0;
      tx_d = 1'b0;
      wait_d = 1'b0;
    end else if (scl_rise && bit_q != BIT_IDLE) begin
      if (bit_q == BIT_FIRST) begin
        if (in_addr_q) begin
          spd_d = 1'b0;
        end else begin
          std_d = 1'b0;
        end
      end
      if (bit_q == BIT_ACK) begin
        ackd_d = !sda_lvl;
      end else begin
        sh_d = {sh_q[6:0], sda_lvl};
      end
    end else if (scl_fall && (bit_q != BIT_IDLE || in_addr_q)) begin
      bit_d = bit_q + 4'h1;
      if (bit_q == BIT_LAST) begin
        if (in_addr_q) begin
          if (mbusy_q) begin
            tx_d = !sh_q[0];
          end else if (sh_q[7:1] == own_q[7:1]) begin
            sel_d = 1'b1;
            tx_d = sh_q[0];
            ack_drv_d = 1'b1;
          end
        end else if (!tx_q && (mbusy_q || sel_q)) begin
          ack_drv_d = 1'b1;
          pend_d = 1'b1;
        end
      end else if (bit_q == BIT_ACK) begin
        bit_d = BIT_FIRST;
        ack_drv_d = 1'b0;
        in_addr_d = 1'b0;
        if (sel_q && tx_q) begin
          wait_d = ackd_q;
          tx_d = ackd_q;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sh_q <= RST_SHIFT;
      bit_q <= BIT_IDLE;
      in_addr_q <= 1'b0;
      tx_q <= 1'b0;
      sel_q <= 1'b0;
      ack_drv_q <= 1'b0;
      std_q <= 1'b0;
      spd_q <= 1'b0;
      ackd_q <= 1'b0;
      pend_q <= 1'b0;
      wait_q <= 1'b0;
      obit_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      sh_q <= sh_d;
      bit_q <= bit_d;
      in_addr_q <= in_addr_d;
      tx_q <= tx_d;
      sel_q <= sel_d;
      ack_drv_q <= ack_drv_d;
      std_q <= std_d;
      spd_q <= spd_d;
      ackd_q <= ackd_d;
      pend_q <= pend_d;
      wait_q <= wait_d;
      obit_q <= obit_d;
      scl_prev_q <= scl_lvl;
      sda_prev_q <= sda_lvl;
    end
  end

  // Data only changes while the synchronised clock level reads low, so edges stay clean
  assign eng_sda_low = eng_drv_ok && ((ack_drv_q && bit_q == BIT_ACK)
    || (tx_q && (mbusy_q || sel_q) && bit_q >= BIT_FIRST && bit_q <= BIT_LAST
    && !obit_q));

  // Open drain: the output value is always low, only the enable moves
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = unit_enable && (m_scl_low || wait_q || pend_q);
  assign sda_oe = unit_enable && (m_sda_low || eng_sda_low);

  assign start_seen_flag = std_q;
  assign stop_seen_flag = spd_q;
  assign ack_seen_flag = ackd_q;
  assign slave_selected = sel_q;
  assign master_busy = mbusy_q;
endmodule
`default_nettype wire

// ### test/twb_core_monitor.sv
// Port-level assertions of the two-wire bus block
`timescale 1ns/1ps
`default_nettype none
module twb_core_monitor
  import twb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic unit_enable,
  input wire logic start_trigger,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic start_seen_flag,
  input wire logic stop_seen_flag,
  input wire logic slave_selected,
  input wire logic master_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_PIN_LOW: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("line driven high");
  AST_OFF_FLAGS: assert property (reg_rd && reg_addr == ADDR_CLK_SEL &&
    !unit_enable && $past(!unit_enable) |=> reg_rdata[5:4] == 2'h0)
    else $error("level flags not zero while disabled");
  AST_ON_LEVEL: assert property ((unit_enable && $stable(scl_i) && $stable(sda_i))[*8]
    ##0 (reg_rd && reg_addr == ADDR_CLK_SEL) |=> reg_rdata[5:4] == $past({scl_i, sda_i}))
    else $error("level flags differ from lines");
  AST_OFF_QUIET: assert property (!unit_enable && $past(!unit_enable) |->
    !scl_oe && !sda_oe && !start_seen_flag && !stop_seen_flag && !slave_selected)
    else $error("activity while disabled");
  AST_START_SEEN: assert property (unit_enable && scl_i && $past(scl_i) &&
    $fell(sda_i) |-> ##[1:10] start_seen_flag)
    else $error("start not flagged");
  AST_STOP_SEEN: assert property (unit_enable && scl_i && $past(scl_i) &&
    $rose(sda_i) |-> ##[1:10] stop_seen_flag)
    else $error("stop not flagged");
  AST_START_REFUSED: assert property (start_trigger && !stop_seen_flag &&
    !master_busy |=> !master_busy)
    else $error("start taken without stop seen");
  AST_START_GO: assert property (unit_enable && start_trigger && stop_seen_flag &&
    !master_busy && !slave_selected |-> ##[1:3] master_busy)
    else $error("start request lost");
  AST_START_SHAPE: assert property ($rose(master_busy) |->
    ##[0:2] (sda_oe && !scl_oe))
    else $error("start not data low with clock released");
  cover property ($rose(start_seen_flag));
  cover property ($rose(slave_selected));
  cover property ($fell(master_busy));
endmodule
bind twb_core twb_core_monitor i_mon (.core_clk, .rst, .reg_addr, .reg_rd, .reg_rdata,
  .unit_enable, .start_trigger, .scl_i, .sda_i, .scl_o, .sda_o, .scl_oe, .sda_oe,
  .start_seen_flag, .stop_seen_flag, .slave_selected, .master_busy);
`default_nettype wire

// ### test/twb_bus_peer.sv
// Far-side bus device: a master, or a slave that acks one byte
`timescale 1ns/1ps
`default_nettype none
module twb_bus_peer #(
  parameter int HALF = 20
) (
  input wire logic core_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  int period;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(posedge core_clk);
    #1;
  endtask
  task automatic hold(input logic c, input logic d);
    scl_low = c;
    sda_low = d;
  endtask
  // Release clock and wait, bounded, while a slave stretches it
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 2000 && scl !== 1'b1; i++) @(posedge core_clk);
    #1;
    half();
  endtask
  task automatic start();
    sda_low = 1'b1;
    half();
    scl_low = 1'b1;
  endtask
  // Nine clocks MSB first; tx[0] low pulls the ninth bit low as ack
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 0; i < 9; i++) begin
      repeat (2) @(posedge core_clk);
      #1 sda_low = !tx[8];
      tx = tx << 1;
      half();
      rise();
      rx = {rx[7:0], sda};
      scl_low = 1'b1;
    end
  endtask
  task automatic stop();
    repeat (2) @(posedge core_clk);
    #1 sda_low = 1'b1;
    half();
    rise();
    sda_low = 1'b0;
    half();
  endtask
  // Acts as addressed slave; keeps one clock period in ns
  task automatic serve(output logic [7:0] rx);
    int t0;
    @(negedge scl);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      if (i == 1) period = int'($time) - t0;
      t0 = int'($time);
      rx = {rx[6:0], sda};
      @(negedge scl);
    end
    repeat (2) @(posedge core_clk);
    #1 sda_low = 1'b1;
    @(negedge scl);
    repeat (2) @(posedge core_clk);
    #1 sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench of the two-wire bus block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, e); end end
module tb_top;
  import twb_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, unit_enable = 1'b0;
  logic start_trigger = 1'b0, stop_trigger = 1'b0, timer_two_out = 1'b0, rx_ready = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rx_data;
  logic scl_oe, sda_oe, p_scl, p_sda, start_seen_flag, stop_seen_flag, ack_seen_flag;
  logic slave_selected, master_busy, rx_valid;
  int n_errors = 0, num_checks = 0;
  // Open-drain lines with pull-up
  wire logic scl = !(scl_oe || p_scl);
  wire logic sda = !(sda_oe || p_sda);
  // Ext bit, clock select; expected clock periods in cycles
  logic [8:0] mode [9] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h008, 9'h00A, 9'h00B,
    9'h00C, 9'h108};
  int per [9] = '{44, 86, 172, 132, 24, 48, 36, 24, 12};
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) #1 timer_two_out = ~timer_two_out;
  twb_core #(.FILT_LEN(2), .FIFO_DEPTH(4)) i_dut (.core_clk, .rst, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .unit_enable, .start_trigger, .stop_trigger,
    .timer_two_out, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe,
    .start_seen_flag, .stop_seen_flag, .ack_seen_flag, .slave_selected, .master_busy,
    .rx_valid, .rx_ready, .rx_data);
  twb_bus_peer #(.HALF(20)) i_peer (.core_clk, .scl, .sda, .scl_low(p_scl), .sda_low(p_sda));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    pulse(reg_wr);
  endtask
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    reg_addr = a;
    pulse(reg_rd);
    `CHK(reg_rdata, e)
  endtask
  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
  initial begin
    logic [8:0] rx;
    logic [7:0] b;
    cyc(3);
    rst = 1'b0;
    rc(ADDR_CLK_SEL, 8'h00);
    rc(ADDR_OWN, 8'h00);
    rc(ADDR_SHIFT, 8'hFF);
    rc(ADDR_EXP, 8'h00);
    rc(32'hFFFFF34C, 8'h00);
    wr(ADDR_CLK_SEL, 8'h3F);
    rc(ADDR_CLK_SEL, 8'h0F);
    unit_enable = 1'b1;
    cyc(10);
    rc(ADDR_CLK_SEL, 8'h3F);
    pulse(start_trigger);
    cyc(4);
    `CHK(master_busy, 1'b0)
    i_peer.hold(1'b1, 1'b0);
    cyc(10);
    rc(ADDR_CLK_SEL, 8'h1F);
    i_peer.hold(1'b0, 1'b0);
    cyc(10);
    rc(ADDR_CLK_SEL, 8'h3F);
    i_peer.hold(1'b0, 1'b1);
    cyc(10);
    rc(ADDR_CLK_SEL, 8'h2F);
    `CHK(start_seen_flag, 1'b1)
    i_peer.hold(1'b0, 1'b0);
    cyc(10);
    `CHK(stop_seen_flag, 1'b1)
    wr(ADDR_CLK_SEL, 8'h00);
    wr(ADDR_OWN, 8'hA4);
    i_peer.start();
    i_peer.xfer({8'hA4, 1'b1}, rx);
    `CHK(rx[0], 1'b0)
    `CHK(slave_selected, 1'b1)
    `CHK(stop_seen_flag, 1'b0)
    rc(ADDR_SHIFT, 8'hA4);
    for (int i = 0; i < 4; i++) i_peer.xfer({8'(8'h30 + i), 1'b1}, rx);
    fork
      i_peer.xfer({8'h34, 1'b1}, rx);
      begin
        cyc(500);
        `CHK(scl, 1'b0)
        for (int i = 0; i < 5; i++) begin
          for (int k = 0; k < 300 && rx_valid !== 1'b1; k++) cyc(1);
          `CHK(rx_data, 8'(8'h30 + i))
          pulse(rx_ready);
        end
      end
    join
    i_peer.stop();
    cyc(10);
    `CHK(stop_seen_flag, 1'b1)
    `CHK(slave_selected, 1'b0)
    i_peer.start();
    i_peer.xfer({8'h40, 1'b1}, rx);
    `CHK({rx[0], slave_selected}, 2'h2)
    i_peer.stop();
    for (int k = 0; k < 9; k++) begin
      wr(ADDR_EXP, {7'h00, mode[k][8]});
      wr(ADDR_CLK_SEL, mode[k][7:0]);
      b = {7'h35, k[0]};
      wr(ADDR_SHIFT, b);
      fork
        i_peer.serve(b);
        pulse(start_trigger);
      join
      `CHK(b, {7'h35, k[0]})
      `CHK(i_peer.period, per[k] * 4)
      `CHK(ack_seen_flag, 1'b1)
      pulse(stop_trigger);
      for (int i = 0; i < 2000 && master_busy !== 1'b0; i++) cyc(1);
      cyc(12);
      `CHK({master_busy, stop_seen_flag}, 2'h1)
    end
    unit_enable = 1'b0;
    cyc(2);
    `CHK(stop_seen_flag, 1'b0)
    finish_test();
  end
endmodule
`default_nettype wire
